// *** ipdc_pkg.sv ***
/*
 * Package for the idle and power-down controller: register layout, reset
 * values, timing counts, state encoding and carrier structs.
 * Assumes a single 250 MHz clock domain; no other files are needed.
 */
// Functional notes
// - Write setting the idle bit ends execution after that write; idle follows.
// - In idle the CPU clock stops; interrupts, timers and serial keep running.
// - CPU state is frozen during idle because its clock is gated.
// - Port pins hold the levels captured when idle was entered.
// - Address latch strobe and program store strobe are driven high in idle.
// - Any enabled interrupt during idle clears the idle bit in hardware.
// - After the handler returns, execution resumes after the idle-entering instruction.
// - Two general flag bits are software read/write with no side effect.
// - Reset ends idle; 24 oscillator periods of reset suffice.
// - Power-down request stops the oscillator after the requesting write.
// - Power-down ends on hardware reset or an external interrupt.
// - Only the two enabled external interrupts wake from power-down, any sense mode.
// - Enabled wake pin low restarts the oscillator; release completes the exit.
// - With both enabled, either low restarts; first release completes the exit.
// - When both wake inputs are involved, the higher-priority handler runs.
// - After wake handler returns, execution continues after the power-down instruction.
// - Interrupt is enabled only with global enable bit 7 and its own enable.
package ipdc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] IPDC_ADDR_PWRCTL = 8'h87; // power_control_register
	localparam logic [7:0] IPDC_ADDR_IRQEN = 8'hA8; // interrupt enable
	localparam logic [7:0] IPDC_ADDR_IRQPRI = 8'hB8; // external irq priority
	localparam logic [7:0] IPDC_ADDR_STATUS = 8'hC0; // block state readback

	// Power control fields
	localparam int IPDC_BIT_IDLE = 0;
	localparam int IPDC_BIT_PDOWN = 1;
	localparam int IPDC_BIT_GENFLAG0 = 2;
	localparam int IPDC_BIT_GENFLAG1 = 3;
	// Interrupt enable fields
	localparam int IPDC_BIT_EXA = 0;
	localparam int IPDC_BIT_EXB = 2;
	localparam int IPDC_BIT_GIE = 7;
	// Priority fields
	localparam int IPDC_BIT_PRIA = 0;
	localparam int IPDC_BIT_PRIB = 2;

	localparam logic [7:0] IPDC_RST_PWRCTL = 8'h00;
	localparam logic [7:0] IPDC_RST_IRQEN = 8'h00;
	localparam logic [7:0] IPDC_RST_IRQPRI = 8'h00;
	localparam logic [7:0] IPDC_RST_PORTS = 8'hFF;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int IPDC_CLK_MHZ = 250;
	localparam int IPDC_RESET_OSC_PERIODS = 24; // two machine cycles
	localparam int IPDC_RESET_CYCLES = IPDC_RESET_OSC_PERIODS;
	localparam int IPDC_OSC_SETTLE_NS = 1000;
	localparam int IPDC_OSC_SETTLE_CYCLES = (IPDC_OSC_SETTLE_NS * IPDC_CLK_MHZ + 999) / 1000;

	typedef enum logic [2:0] {
		IPDC_RUN = 3'b000,
		IPDC_IDLE = 3'b001,
		IPDC_PDOWN = 3'b010,
		IPDC_WAKE = 3'b011,
		IPDC_RESUME = 3'b100
	} ipdc_state_t;

	// Register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} ipdc_bus_t;

	// Pin-facing frozen outputs
	typedef struct packed {
		logic [7:0] port;
		logic ale;
		logic progStrobe;
	} ipdc_pins_t;

endpackage

// *** ipdc_idle_powerdown_control.sv ***
/*
 * Idle and power-down controller. Gates the CPU clock in idle, stops the
 * oscillator in power-down, and wakes on enabled interrupts or reset.
 * Assumes the CPU drives ports and strobes through this block, and that
 * external wake pins and the hardware reset pin are asynchronous.
 */
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
module ipdc_idle_powerdown_control import ipdc_pkg::*; #(
	parameter int SETTLE_CYCLES = IPDC_OSC_SETTLE_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire ipdc_bus_t bus,
	output logic [7:0] rdata,
	input wire logic [7:0] periphIrq,
	input wire logic extIrqA_n,
	input wire logic extIrqB_n,
	input wire logic hwReset,
	input wire logic irqReturned,
	input wire ipdc_pins_t cpuPins,
	output ipdc_pins_t pinsOut,
	output logic cpuClkEn,
	output logic oscRun,
	output logic cpuHalt,
	output logic cpuReset,
	output logic [1:0] wakeVector,
	output logic wakeVecValid
);

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [1:0] syncA_r, syncB_r;
	logic [1:0] syncA_nxt, syncB_nxt;
	logic pinA_n, pinB_n, pinRst;

	// Two flops per asynchronous pin; only stage two is read
	always_comb begin
		syncA_nxt = {syncA_r[0], extIrqA_n};
		syncB_nxt = {syncB_r[0], extIrqB_n};
	end
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			syncA_r <= 2'h3;
			syncB_r <= 2'h3;
		end else begin
			syncA_r <= syncA_nxt;
			syncB_r <= syncB_nxt;
		end
	end
	logic [1:0] rstSync_r, rstSync_nxt;
	always_comb rstSync_nxt = {rstSync_r[0], hwReset};
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			rstSync_r <= 2'h0;
		else
			rstSync_r <= rstSync_nxt;
	end
	assign pinA_n = syncA_r[1];
	assign pinB_n = syncB_r[1];
	assign pinRst = rstSync_r[1];

	// ************************************************************
	// Registers and state
	// ************************************************************
	logic [7:0] pwrCtl_r, pwrCtl_nxt;
	logic [7:0] irqEn_r, irqEn_nxt;
	logic [7:0] irqPri_r, irqPri_nxt;
	logic [7:0] rdata_nxt;
	ipdc_state_t state_r, state_nxt;
	ipdc_pins_t frozen_r, frozen_nxt;
	logic [15:0] cnt_r, cnt_nxt;
	logic [1:0] wakeVector_nxt;
	logic wakeVecValid_r, wakeVecValid_nxt;
	logic [1:0] lowSeen_r, lowSeen_nxt;
	logic enA, enB, anyEnabled, resetHeld;

	// Wake sources count only with global and own enable
	assign enA = irqEn_r[IPDC_BIT_GIE] & irqEn_r[IPDC_BIT_EXA];
	assign enB = irqEn_r[IPDC_BIT_GIE] & irqEn_r[IPDC_BIT_EXB];
	assign anyEnabled = irqEn_r[IPDC_BIT_GIE] & |(irqEn_r[6:0] & periphIrq[6:0]);
	// Reset counts once held for the full 24 periods
	assign resetHeld = pinRst && (cnt_r >= 16'(IPDC_RESET_CYCLES - 1));

	always_comb begin
		pwrCtl_nxt = pwrCtl_r;
		irqEn_nxt = irqEn_r;
		irqPri_nxt = irqPri_r;
		state_nxt = state_r;
		frozen_nxt = frozen_r;
		cnt_nxt = cnt_r;
		wakeVector_nxt = wakeVector;
		wakeVecValid_nxt = 1'b0;
		lowSeen_nxt = lowSeen_r;
		rdata_nxt = 8'h00;
		// Register reads answer one cycle later
		if (bus.rd) begin
			case (bus.addr)
				IPDC_ADDR_PWRCTL: rdata_nxt = pwrCtl_r;
				IPDC_ADDR_IRQEN: rdata_nxt = irqEn_r;
				IPDC_ADDR_IRQPRI: rdata_nxt = irqPri_r;
				IPDC_ADDR_STATUS: rdata_nxt = {3'h0, lowSeen_r, state_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
		// Writes; flag bits are plain storage
		if (bus.wr) begin
			case (bus.addr)
				IPDC_ADDR_PWRCTL: pwrCtl_nxt = bus.wdata;
				IPDC_ADDR_IRQEN: irqEn_nxt = bus.wdata;
				IPDC_ADDR_IRQPRI: irqPri_nxt = bus.wdata;
				default: ;
			endcase
		end
		// Reset pin is counted while held high, except in power-down and wake
		if (pinRst)
			cnt_nxt = (state_r == IPDC_PDOWN || state_r == IPDC_WAKE) ? cnt_r : cnt_r + 16'h0001;
		case (state_r)
			IPDC_RUN: begin
				if (!pinRst)
					cnt_nxt = 16'h0000;
				// Request write is the last executed; power-down wins
				if (bus.wr && bus.addr == IPDC_ADDR_PWRCTL) begin
					frozen_nxt = cpuPins;
					if (bus.wdata[IPDC_BIT_PDOWN])
						state_nxt = IPDC_PDOWN;
					else if (bus.wdata[IPDC_BIT_IDLE])
						state_nxt = IPDC_IDLE;
				end
			end
			IPDC_IDLE: begin
				// Enabled interrupt clears idle in hardware; set by bus loses
				if (anyEnabled) begin
					pwrCtl_nxt[IPDC_BIT_IDLE] = 1'b0;
					state_nxt = IPDC_RESUME;
				end else if (resetHeld) begin
					state_nxt = IPDC_RUN;
					pwrCtl_nxt = IPDC_RST_PWRCTL;
				end
				if (!pinRst)
					cnt_nxt = 16'h0000;
			end
			IPDC_PDOWN: begin
				// Only enabled external pins or reset restart the oscillator
				lowSeen_nxt = {enB & ~pinB_n, enA & ~pinA_n};
				if (pinRst || (enA && !pinA_n) || (enB && !pinB_n)) begin
					state_nxt = IPDC_WAKE;
					cnt_nxt = 16'h0000;
				end
			end
			IPDC_WAKE: begin
				// Oscillator settles, then first release completes the exit
				lowSeen_nxt = lowSeen_r | {enB & ~pinB_n, enA & ~pinA_n};
				if (cnt_r < 16'(SETTLE_CYCLES))
					cnt_nxt = cnt_r + 16'h0001;
				if (pinRst && cnt_r >= 16'(SETTLE_CYCLES)) begin
					state_nxt = IPDC_RUN;
					pwrCtl_nxt = IPDC_RST_PWRCTL;
					cnt_nxt = 16'h0000;
				end else if (cnt_r >= 16'(SETTLE_CYCLES) &&
				             ((lowSeen_r[0] && pinA_n) || (lowSeen_r[1] && pinB_n))) begin
					pwrCtl_nxt[IPDC_BIT_PDOWN] = 1'b0;
					pwrCtl_nxt[IPDC_BIT_IDLE] = 1'b0;
					state_nxt = IPDC_RESUME;
					// Settle count must not shorten a reset that follows the wake
					cnt_nxt = 16'h0000;
					wakeVecValid_nxt = 1'b1;
					// Higher priority handler; tie goes to source A
					if (lowSeen_r == 2'b11)
						wakeVector_nxt = (irqPri_r[IPDC_BIT_PRIB] && !irqPri_r[IPDC_BIT_PRIA]) ?
							2'd1 : 2'd0;
					else
						wakeVector_nxt = lowSeen_r[1] ? 2'd1 : 2'd0;
				end else if (!pinRst && lowSeen_r == 2'b00 && (!enA || pinA_n) && (!enB || pinB_n)) begin
					state_nxt = IPDC_PDOWN; // glitch: go back to sleep
				end
			end
			IPDC_RESUME: begin
				// CPU runs the handler; a held reset still wins over the return
				if (resetHeld) begin
					state_nxt = IPDC_RUN;
					pwrCtl_nxt = IPDC_RST_PWRCTL;
				end else if (irqReturned)
					state_nxt = IPDC_RUN;
				if (!pinRst)
					cnt_nxt = 16'h0000;
			end
			default: state_nxt = IPDC_RUN;
		endcase
	end

	// State registers only
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pwrCtl_r <= IPDC_RST_PWRCTL;
			irqEn_r <= IPDC_RST_IRQEN;
			irqPri_r <= IPDC_RST_IRQPRI;
			state_r <= IPDC_RUN;
			frozen_r <= '{port: IPDC_RST_PORTS, ale: 1'b1, progStrobe: 1'b1};
			cnt_r <= 16'h0000;
			rdata <= 8'h00;
			wakeVector <= 2'd0;
			wakeVecValid_r <= 1'b0;
			lowSeen_r <= 2'b00;
		end else begin
			pwrCtl_r <= pwrCtl_nxt;
			irqEn_r <= irqEn_nxt;
			irqPri_r <= irqPri_nxt;
			state_r <= state_nxt;
			frozen_r <= frozen_nxt;
			cnt_r <= cnt_nxt;
			rdata <= rdata_nxt;
			wakeVector <= wakeVector_nxt;
			wakeVecValid_r <= wakeVecValid_nxt;
			lowSeen_r <= lowSeen_nxt;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	logic sleeping;
	assign sleeping = (state_r == IPDC_IDLE) || (state_r == IPDC_PDOWN) || (state_r == IPDC_WAKE);
	// Gating the CPU clock is what keeps every CPU register intact
	assign cpuClkEn = !sleeping;
	assign cpuHalt = sleeping;
	assign oscRun = (state_r != IPDC_PDOWN);
	assign cpuReset = resetHeld;
	assign wakeVecValid = wakeVecValid_r;
	// Pins frozen while asleep; strobes forced high
	always_comb begin
		pinsOut = cpuPins;
		if (sleeping) begin
			pinsOut.port = frozen_r.port;
			pinsOut.ale = 1'b1;
			pinsOut.progStrobe = 1'b1;
		end
	end

endmodule // ipdc_idle_powerdown_control

// *** ipdc_props.sv ***
/*
 * Checker for the idle and power-down controller top ports.
 * Assumes one clock domain and a bind onto the controller.
 */
`timescale 1ns/100ps
module ipdc_props import ipdc_pkg::*; #(
	parameter int SETTLE_CYCLES = IPDC_OSC_SETTLE_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire ipdc_bus_t bus,
	input wire logic [7:0] rdata,
	input wire logic extIrqA_n,
	input wire logic extIrqB_n,
	input wire logic hwReset,
	input wire ipdc_pins_t pinsOut,
	input wire logic cpuClkEn,
	input wire logic oscRun,
	input wire logic cpuHalt,
	input wire logic cpuReset,
	input wire logic wakeVecValid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic [3:0] lowHist_r;
	logic [4:0] hwCnt_r;
	logic pdSeen_r;
	logic ctlWr;
	// Wake cause history covers the two sync stages plus the state register
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			lowHist_r <= 4'h0;
			hwCnt_r <= 5'h00;
			pdSeen_r <= 1'b0;
		end else begin
			lowHist_r <= {lowHist_r[2:0], !extIrqA_n || !extIrqB_n || hwReset};
			hwCnt_r <= !hwReset ? 5'h00 : hwCnt_r + {4'h0, hwCnt_r != 5'h1f};
			// A reset that meets a stopped oscillator also waits for its restart
			pdSeen_r <= hwReset && (pdSeen_r || !oscRun);
		end
	end
	assign ctlWr = bus.wr && bus.addr == IPDC_ADDR_PWRCTL && cpuClkEn;
	// ************************************************************
	// Properties
	// ************************************************************
	a_idle_entry: assert property (ctlWr && bus.wdata[IPDC_BIT_IDLE] |=> !cpuClkEn) else $error("idle not entered");
	a_pdown_entry: assert property (ctlWr && bus.wdata[IPDC_BIT_PDOWN] |=> !oscRun) else $error("osc still runs");
	a_halt_match: assert property (cpuHalt != cpuClkEn) else $error("halt mismatch");
	a_port_frozen: assert property (!cpuClkEn && $past(!cpuClkEn) |-> $stable(pinsOut.port)) else $error("port moved");
	a_strobes_high: assert property (!cpuClkEn |-> pinsOut.ale && pinsOut.progStrobe) else $error("strobe low");
	a_osc_cause: assert property ($rose(oscRun) |-> |lowHist_r) else $error("osc woke alone");
	a_exit_release: assert property (wakeVecValid |-> extIrqA_n || extIrqB_n) else $error("exit while held");
	a_vec_pulse: assert property (wakeVecValid |=> !wakeVecValid) else $error("vector valid too long");
	a_reset_min: assert property ($rose(cpuReset) |-> hwCnt_r >= 5'h18) else $error("reset too early");
	a_reset_due: assert property (hwCnt_r == 5'h1e && !pdSeen_r |-> cpuReset) else $error("reset missing");
	a_read_quiet: assert property (!$past(bus.rd) |-> rdata == 8'h00) else $error("stray read data");
endmodule // ipdc_props

bind ipdc_idle_powerdown_control ipdc_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props (.mclk, .reset_n, .bus,
	.rdata, .extIrqA_n, .extIrqB_n, .hwReset, .pinsOut, .cpuClkEn, .oscRun, .cpuHalt, .cpuReset, .wakeVecValid);

// *** ipdc_cpu_model.sv ***
/*
 * CPU core and wake pin model facing the controller.
 * Assumes the bench commands handler returns and pin presses.
 */
`timescale 1ns/100ps
module ipdc_cpu_model import ipdc_pkg::*; (
	input wire logic mclk,
	input wire logic cpuClkEn,
	input wire logic returnReq,
	input wire logic pressA,
	input wire logic pressB,
	output ipdc_pins_t cpuPins,
	output logic irqReturned,
	output logic extIrqA_n,
	output logic extIrqB_n
);
	logic [9:0] cnt_r = 10'h000;
	// Pin activity runs on every edge, so a controller that fails to freeze shows it
	always @(posedge mclk) begin
		cnt_r <= cnt_r + 10'h001;
	end
	assign cpuPins = '{port: cnt_r[9:2], ale: cnt_r[0], progStrobe: cnt_r[1]};
	// A stopped CPU cannot return from a handler
	assign irqReturned = returnReq && cpuClkEn;
	// Pins idle high; presses are held well past oscillator settling
	assign extIrqA_n = !pressA;
	assign extIrqB_n = !pressB;
endmodule // ipdc_cpu_model

// *** testbench.sv ***
/*
 * Testbench for the idle and power-down controller.
 * Assumes the checker is bound and a short settle count.
 */
`timescale 1ns/100ps
module testbench import ipdc_pkg::*;;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	ipdc_bus_t bus = '0;
	logic [7:0] periphIrq = 8'h00;
	logic hwReset = 1'b0;
	logic returnReq = 1'b0;
	logic [7:0] entryPort = 8'h00;
	logic pressA = 1'b0;
	logic pressB = 1'b0;
	logic [7:0] rdata, v;
	ipdc_pins_t cpuPins, pinsOut;
	logic cpuClkEn, oscRun, cpuHalt, cpuReset, wakeVecValid, irqReturned, extIrqA_n, extIrqB_n;
	logic [1:0] wakeVector;
	logic [7:0] addrs [4] = '{IPDC_ADDR_PWRCTL, IPDC_ADDR_IRQEN, IPDC_ADDR_IRQPRI, 8'h55};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	int i, k;
	always #2 mclk = ~mclk;
	ipdc_idle_powerdown_control #(.SETTLE_CYCLES(4)) DUT (.mclk, .reset_n, .bus, .rdata, .periphIrq, .extIrqA_n,
		.extIrqB_n, .hwReset, .irqReturned, .cpuPins, .pinsOut, .cpuClkEn, .oscRun, .cpuHalt, .cpuReset, .wakeVector,
		.wakeVecValid);
	ipdc_cpu_model u_cpu (.mclk, .cpuClkEn, .returnReq, .pressA, .pressB, .cpuPins, .irqReturned, .extIrqA_n,
		.extIrqB_n);
	// Port level on the CPU side at the edge that takes a power control write
	always @(posedge mclk) begin
		if (bus.wr && bus.addr == IPDC_ADDR_PWRCTL)
			entryPort <= cpuPins.port;
	end
	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	// One strobe cycle, then read data sampled in the following cycle
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge mclk);
		bus <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge mclk);
		bus <= '0;
		#1 v = rdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		acc(a, 8'h00, 1'b0);
		chk(v & m, e);
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic handler_return();
		returnReq <= 1'b1;
		waitc(1);
		returnReq <= 1'b0;
		waitc(3);
	endtask
	task automatic finish_test();
		if (error_cnt == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// Hang guard, well above the few hundred cycles the run needs
	always @(posedge mclk) begin
		cyc++;
		if (cyc > 4000) begin
			error_cnt++;
			finish_test();
		end
	end
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (20) @(posedge mclk);
		reset_n <= 1'b1;
		for (i = 0; i < 4; i++) begin
			rdc(addrs[i], 8'h00, 8'hff);
		end
		acc(IPDC_ADDR_PWRCTL, 8'h0c, 1'b1);
		rdc(IPDC_ADDR_PWRCTL, 8'h0c, 8'hff);
		// Idle ignores a disabled source, then wakes on an enabled one
		acc(IPDC_ADDR_IRQEN, 8'h85, 1'b1);
		acc(IPDC_ADDR_PWRCTL, 8'h0d, 1'b1);
		periphIrq <= 8'h02;
		waitc(8);
		chk({7'h00, cpuClkEn}, 8'h00);
		chk(pinsOut.port, entryPort);
		chk({6'h00, pinsOut.ale, pinsOut.progStrobe}, 8'h03);
		rdc(IPDC_ADDR_STATUS, 8'h01, 8'h07);
		periphIrq <= 8'h01;
		waitc(6);
		periphIrq <= 8'h00;
		rdc(IPDC_ADDR_PWRCTL, 8'h0c, 8'hff);
		rdc(IPDC_ADDR_STATUS, 8'h04, 8'h07);
		handler_return();
		chk({7'h00, cpuClkEn}, 8'h01);
		// Reset ends idle
		acc(IPDC_ADDR_PWRCTL, 8'h01, 1'b1);
		hwReset <= 1'b1;
		waitc(32);
		chk({7'h00, cpuReset}, 8'h01);
		hwReset <= 1'b0;
		waitc(32);
		rdc(IPDC_ADDR_STATUS, 8'h00, 8'h07);
		rdc(IPDC_ADDR_PWRCTL, 8'h00, 8'hff);
		// Power-down wake by one pin, then by both with the second one ranked higher
		for (i = 0; i < 2; i++) begin
			acc(IPDC_ADDR_IRQEN, 8'h85, 1'b1);
			acc(IPDC_ADDR_IRQPRI, i ? 8'h04 : 8'h00, 1'b1);
			acc(IPDC_ADDR_PWRCTL, 8'h0f, 1'b1);
			rdc(IPDC_ADDR_STATUS, 8'h02, 8'h07);
			chk({7'h00, oscRun}, 8'h00);
			pressA <= 1'b1;
			pressB <= i[0];
			waitc(12);
			chk({7'h00, oscRun}, 8'h01);
			chk(pinsOut.port, entryPort);
			rdc(IPDC_ADDR_STATUS, 8'h03, 8'h07);
			pressA <= 1'b0;
			for (k = 0; k < 20 && wakeVecValid !== 1'b1; k++) waitc(1);
			chk({7'h00, wakeVecValid}, 8'h01);
			chk({6'h00, wakeVector}, {7'h00, i[0]});
			pressB <= 1'b0;
			rdc(IPDC_ADDR_PWRCTL, 8'h0c, 8'hff);
			handler_return();
			rdc(IPDC_ADDR_STATUS, 8'h00, 8'h07);
		end
		// Without the global enable a pin press must not wake
		acc(IPDC_ADDR_IRQEN, 8'h05, 1'b1);
		acc(IPDC_ADDR_PWRCTL, 8'h02, 1'b1);
		pressA <= 1'b1;
		waitc(12);
		chk({7'h00, oscRun}, 8'h00);
		// A hardware reset still ends power-down once the oscillator has settled
		hwReset <= 1'b1;
		waitc(40);
		chk({7'h00, oscRun}, 8'h01);
		chk({7'h00, cpuReset}, 8'h01);
		hwReset <= 1'b0;
		pressA <= 1'b0;
		waitc(4);
		rdc(IPDC_ADDR_STATUS, 8'h00, 8'h07);
		rdc(IPDC_ADDR_PWRCTL, 8'h00, 8'hff);
		finish_test();
	end
endmodule // testbench
